// ### hw/timer_pin_function_select.sv
// pin-function selection for four timer channel pins and the shared reset/port pin
//
// Operation
// - channel a drives the compare waveform with disable 0, dual-pulse select 1, io top 0 and low bits 01 or 1x, and is a capture input for io top 1.
// - channel a is the external trigger input when its disable is 1, dual-pulse select is 0 and the trigger edge field is 01 or 1x.
// - channel b drives the dual-pulse waveform whenever its disable and the dual-pulse select are both 0.
// - with dual-pulse select 1, channel b drives pwm, the compare waveform or becomes a capture input by its disable, pulse select and io field.
// - channel c follows the same pwm, compare and capture selection as channel b under dual-pulse select 1.
// - channel d follows the same pwm, compare and capture selection as channel b under dual-pulse select 1.
// - out of reset the shared pin is the active-low hardware reset input.
// - the shared pin becomes a port only once software clears the reset-pin function enable.
// - port pins leave reset as inputs until software sets their direction bits.
`timescale 1ns/1ps
module timer_pin_function_select
  import pin_select_pkg::*;
(
  input  wire logic        clk,               // system clock, 40 MHz
  input  wire logic        rst,               // async reset, active high
  input  wire logic [5:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read request
  input  wire logic        avs_write,         // write request
  input  wire logic [31:0] avs_writedata,     // write data
  output logic      [31:0] avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  input  wire logic [3:0]  chan_pin_in,       // channel pin levels a..d
  output logic      [3:0]  chan_pin_out,      // channel pin drive levels
  output logic      [3:0]  chan_pin_oe,       // channel pin enables
  input  wire logic [3:0]  compare_wave,      // timer compare waveforms a..d
  input  wire logic [3:0]  pwm_wave,          // timer pwm waveforms, bit 0 unused
  input  wire logic        dual_wave,         // timer dual-pulse waveform
  output logic      [3:0]  capture_in,        // capture inputs to timer
  output logic             external_trigger_input, // trigger input to timer
  input  wire logic        shared_pin_in,     // shared reset/port pin level
  output logic             shared_pin_out,    // shared pin drive level
  output logic             shared_pin_oe,     // shared pin enable
  output logic             hw_reset_req       // hardware reset request, pin held low
);
  // ==========================================================================
  // registers
  logic [3:0] timer_output_disable_reg;
  logic [7:0] timer_mode_reg;
  logic [6:0] io_control_reg_first;
  logic [6:0] io_control_reg_second;
  logic [1:0] trigger_edge_select;
  logic [4:0] port_dir_ff;
  logic [4:0] port_data_ff;
  logic [4:0] shared_pin_mode_reg;
  logic       reset_pin_write_protect;
  logic       waitrequest_ff;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;
  logic [3:0] capture_ff;
  logic       trigger_ff;
  logic       hw_reset_req_ff;
  logic       do_write;
  logic       reset_pin_function_enable;
  logic       dual_pulse_mode_select;
  logic [3:0] pulse_sel;
  logic [2:0] io_field [4];
  pin_fn_t    fn [4];
  pin_fn_t    shared_fn;
  logic [11:0] fn_status;

  assign dual_pulse_mode_select    = timer_mode_reg[DUAL_SEL_BIT];
  assign pulse_sel                 = {timer_mode_reg[PULSE_D_BIT], timer_mode_reg[PULSE_C_BIT],
                                      timer_mode_reg[PULSE_B_BIT], 1'b0};
  assign io_field[0]               = io_control_reg_first[IO_LO_POS +: 3];
  assign io_field[1]               = io_control_reg_first[IO_HI_POS +: 3];
  assign io_field[2]               = io_control_reg_second[IO_LO_POS +: 3];
  assign io_field[3]               = io_control_reg_second[IO_HI_POS +: 3];
  assign reset_pin_function_enable = shared_pin_mode_reg[RST_PIN_EN_BIT];

  // ==========================================================================
  // bus slave: one wait cycle, request taken on the edge with waitrequest low
  assign do_write        = avs_write & ~waitrequest_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign avs_readdata    = readdata_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest_ff <= 1'b1;
    end else if ((avs_read | avs_write) & waitrequest_ff) begin
      waitrequest_ff <= 1'b0;
    end else begin
      waitrequest_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    if (avs_address == OFS_OUT_DISABLE) begin
      nxt_readdata[3:0] = timer_output_disable_reg;
    end else if (avs_address == OFS_TIMER_MODE) begin
      nxt_readdata[7:0] = timer_mode_reg;
    end else if (avs_address == OFS_IO_FIRST) begin
      nxt_readdata[6:0] = io_control_reg_first;
    end else if (avs_address == OFS_IO_SECOND) begin
      nxt_readdata[6:0] = io_control_reg_second;
    end else if (avs_address == OFS_CTRL_SECOND) begin
      nxt_readdata[1:0] = trigger_edge_select;
    end else if (avs_address == OFS_PORT_DIR) begin
      nxt_readdata[4:0] = port_dir_ff;
    end else if (avs_address == OFS_PORT_DATA) begin
      nxt_readdata[4:0] = port_data_ff;
    end else if (avs_address == OFS_SHARED_MODE) begin
      nxt_readdata[4:0] = shared_pin_mode_reg;
    end else if (avs_address == OFS_WRITE_PROT) begin
      nxt_readdata[PROT_WE_BIT] = reset_pin_write_protect;
    end else if (avs_address == OFS_PIN_LEVEL) begin
      nxt_readdata[4:0] = {shared_pin_in, chan_pin_in};
    end else if (avs_address == OFS_PIN_FUNCTION) begin
      nxt_readdata[11:0]          = fn_status;
      nxt_readdata[SHARED_FN_BIT] = reset_pin_function_enable;
    end
  end

  // data is set up during the wait cycle and stands at the taking edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_ff <= 32'h0000_0000;
    end else if (avs_read & waitrequest_ff) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // ==========================================================================
  // timer configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_output_disable_reg <= RST_OUT_DISABLE;
      timer_mode_reg           <= RST_TIMER_MODE;
      io_control_reg_first     <= RST_IO_CTRL;
      io_control_reg_second    <= RST_IO_CTRL;
      trigger_edge_select      <= RST_EDGE_SEL;
    end else if (do_write) begin
      if (avs_address == OFS_OUT_DISABLE) begin
        timer_output_disable_reg <= avs_writedata[3:0];
      end else if (avs_address == OFS_TIMER_MODE) begin
        timer_mode_reg <= avs_writedata[7:0];
      end else if (avs_address == OFS_IO_FIRST) begin
        io_control_reg_first <= avs_writedata[6:0];
      end else if (avs_address == OFS_IO_SECOND) begin
        io_control_reg_second <= avs_writedata[6:0];
      end else if (avs_address == OFS_CTRL_SECOND) begin
        trigger_edge_select <= avs_writedata[1:0];
      end
    end
  end

  // ==========================================================================
  // port registers; inputs out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_dir_ff  <= RST_PORT_DIR;
      port_data_ff <= RST_PORT_DATA;
    end else if (do_write) begin
      if (avs_address == OFS_PORT_DIR) begin
        port_dir_ff <= avs_writedata[4:0];
      end else if (avs_address == OFS_PORT_DATA) begin
        port_data_ff <= avs_writedata[4:0];
      end
    end
  end

  // ==========================================================================
  // shared pin mode, guarded by its write enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_pin_write_protect <= RST_PROT_WE;
    end else if (do_write && avs_address == OFS_WRITE_PROT) begin
      reset_pin_write_protect <= avs_writedata[PROT_WE_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shared_pin_mode_reg <= RST_SHARED_MODE;
    end else if (do_write && avs_address == OFS_SHARED_MODE && reset_pin_write_protect) begin
      // unprotected writes are dropped silently
      shared_pin_mode_reg <= {avs_writedata[RST_PIN_EN_BIT], 3'b000, avs_writedata[OPEN_DRAIN_BIT]};
    end
  end

  // ==========================================================================
  // channel function decode and pin drive
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_chan
      chan_pin_mux #(
        .IS_A (i == 0),
        .IS_B (i == 1)
      ) u_mux (
        .out_disable (timer_output_disable_reg[i]),
        .dual_sel    (dual_pulse_mode_select),
        .pulse_sel   (pulse_sel[i]),
        .io_field    (io_field[i]),
        .edge_sel    (trigger_edge_select),
        .fn          (fn[i])
      );
      pin_driver u_drv (
        .clk          (clk),
        .rst          (rst),
        .fn           (fn[i]),
        .compare_wave (compare_wave[i]),
        .pwm_wave     (pwm_wave[i]),
        .dual_wave    (dual_wave),
        .port_dir     (port_dir_ff[i]),
        .port_data    (port_data_ff[i]),
        .open_drain   (1'b0),
        .pin_out_ff   (chan_pin_out[i]),
        .pin_oe_ff    (chan_pin_oe[i])
      );
      assign fn_status[3*i +: 3] = fn[i];
    end
  endgenerate

  // timer inputs read zero unless the pin is selected for them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_ff <= 4'h0;
      trigger_ff <= 1'b0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        capture_ff[k] <= (fn[k] == FN_CAPTURE) & chan_pin_in[k];
      end
      trigger_ff <= (fn[0] == FN_TRIGGER) & chan_pin_in[0];
    end
  end
  assign capture_in             = capture_ff;
  assign external_trigger_input = trigger_ff;

  // ==========================================================================
  // shared reset/port pin
  assign shared_fn = reset_pin_function_enable ? FN_RESET : FN_PORT;

  pin_driver u_shared (
    .clk          (clk),
    .rst          (rst),
    .fn           (shared_fn),
    .compare_wave (1'b0),
    .pwm_wave     (1'b0),
    .dual_wave    (1'b0),
    .port_dir     (port_dir_ff[SHARED_PORT_BIT]),
    .port_data    (port_data_ff[SHARED_PORT_BIT]),
    .open_drain   (shared_pin_mode_reg[OPEN_DRAIN_BIT]),
    .pin_out_ff   (shared_pin_out),
    .pin_oe_ff    (shared_pin_oe)
  );

  // low pin requests reset only while the reset function owns the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hw_reset_req_ff <= 1'b0;
    end else begin
      hw_reset_req_ff <= reset_pin_function_enable & ~shared_pin_in;
    end
  end
  assign hw_reset_req = hw_reset_req_ff;

endmodule

// ### common/pin_select_pkg.sv
// constants and types shared by the timer pin-function selection block
package pin_select_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [5:0] OFS_OUT_DISABLE  = 6'h00;
  localparam logic [5:0] OFS_TIMER_MODE   = 6'h04;
  localparam logic [5:0] OFS_IO_FIRST     = 6'h08;
  localparam logic [5:0] OFS_IO_SECOND    = 6'h0c;
  localparam logic [5:0] OFS_CTRL_SECOND  = 6'h10;
  localparam logic [5:0] OFS_PORT_DIR     = 6'h14;
  localparam logic [5:0] OFS_PORT_DATA    = 6'h18;
  localparam logic [5:0] OFS_SHARED_MODE  = 6'h1c;
  localparam logic [5:0] OFS_WRITE_PROT   = 6'h20;
  localparam logic [5:0] OFS_PIN_LEVEL    = 6'h24;
  localparam logic [5:0] OFS_PIN_FUNCTION = 6'h28;

  // ==========================================================================
  // field positions
  localparam int DUAL_SEL_BIT    = 7;
  localparam int PULSE_B_BIT     = 1;
  localparam int PULSE_C_BIT     = 2;
  localparam int PULSE_D_BIT     = 3;
  localparam int IO_LO_POS       = 0;
  localparam int IO_HI_POS       = 4;
  localparam int OPEN_DRAIN_BIT  = 0;
  localparam int RST_PIN_EN_BIT  = 4;
  localparam int PROT_WE_BIT     = 0;
  localparam int SHARED_PORT_BIT = 4;
  localparam int SHARED_FN_BIT   = 12;

  // ==========================================================================
  // values after reset
  localparam logic [3:0] RST_OUT_DISABLE = 4'hf;
  localparam logic [7:0] RST_TIMER_MODE  = 8'h80;
  localparam logic [6:0] RST_IO_CTRL     = 7'h00;
  localparam logic [1:0] RST_EDGE_SEL    = 2'h0;
  localparam logic [4:0] RST_PORT_DIR    = 5'h00;
  localparam logic [4:0] RST_PORT_DATA   = 5'h00;
  localparam logic [4:0] RST_SHARED_MODE = 5'h11;
  localparam logic       RST_PROT_WE     = 1'b0;

  // ==========================================================================
  // pin functions
  typedef enum logic [2:0] {
    FN_PORT    = 3'b000,
    FN_COMPARE = 3'b001,
    FN_PWM     = 3'b010,
    FN_DUAL    = 3'b011,
    FN_CAPTURE = 3'b100,
    FN_TRIGGER = 3'b101,
    FN_RESET   = 3'b110
  } pin_fn_t;

endpackage

// ### hw/chan_pin_mux.sv
// function decode for one timer channel pin
`timescale 1ns/1ps
module chan_pin_mux
  import pin_select_pkg::*;
#(
  parameter bit IS_A = 1'b0,           // channel a: trigger input, no pulse output
  parameter bit IS_B = 1'b0            // channel b: carries the dual-pulse waveform
) (
  input  wire logic       out_disable, // channel output disable
  input  wire logic       dual_sel,    // dual-pulse mode select
  input  wire logic       pulse_sel,   // channel pulse select
  input  wire logic [2:0] io_field,    // channel io field
  input  wire logic [1:0] edge_sel,    // trigger edge select
  output pin_select_pkg::pin_fn_t fn   // decoded pin function
);
  logic io_compare;

  // low bits 01 or 1x
  assign io_compare = io_field[1] | io_field[0];

  always_comb begin
    fn = FN_PORT;
    if (IS_A) begin
      if (dual_sel) begin
        if (io_field[2]) begin
          fn = FN_CAPTURE;
        end else if (!out_disable && io_compare) begin
          fn = FN_COMPARE;
        end
      end else if (out_disable && (edge_sel[1] | edge_sel[0])) begin
        fn = FN_TRIGGER;
      end
    end else if (!dual_sel) begin
      if (IS_B && !out_disable) begin
        fn = FN_DUAL;
      end
    end else if (pulse_sel) begin
      if (!out_disable) begin
        fn = FN_PWM;
      end
    end else if (io_field[2]) begin
      fn = FN_CAPTURE;
    end else if (!out_disable && io_compare) begin
      fn = FN_COMPARE;
    end
  end
endmodule

// ### hw/pin_driver.sv
// registered output and enable for one pin, timer waveform or port latch
`timescale 1ns/1ps
module pin_driver
  import pin_select_pkg::*;
(
  input  wire logic    clk,          // system clock
  input  wire logic    rst,          // async reset, active high
  input  pin_select_pkg::pin_fn_t fn, // selected pin function
  input  wire logic    compare_wave, // output-compare waveform
  input  wire logic    pwm_wave,     // pwm waveform
  input  wire logic    dual_wave,    // dual-pulse waveform
  input  wire logic    port_dir,     // port direction, 1 = output
  input  wire logic    port_data,    // port data latch
  input  wire logic    open_drain,   // drive low only
  output logic         pin_out_ff,   // pin output level
  output logic         pin_oe_ff     // pin output enable
);
  logic nxt_pin_out;
  logic nxt_pin_oe;

  always_comb begin
    nxt_pin_out = 1'b0;
    nxt_pin_oe  = 1'b0;
    case (fn)
      FN_COMPARE: begin
        nxt_pin_out = compare_wave;
        nxt_pin_oe  = 1'b1;
      end
      FN_PWM: begin
        nxt_pin_out = pwm_wave;
        nxt_pin_oe  = 1'b1;
      end
      FN_DUAL: begin
        nxt_pin_out = dual_wave;
        nxt_pin_oe  = 1'b1;
      end
      FN_PORT: begin
        // open drain releases the pin for a high level
        nxt_pin_out = open_drain ? 1'b0 : port_data;
        nxt_pin_oe  = port_dir & ~(open_drain & port_data);
      end
      default: begin
        nxt_pin_out = 1'b0;
        nxt_pin_oe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff  <= 1'b0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
    end
  end
endmodule

// ### verif/timer_pin_props.sv
// assertion checker for the timer pin-function selection block
`timescale 1ns/1ps
module timer_pin_props
  import pin_select_pkg::*;
(
  input wire logic        clk,                    // system clock
  input wire logic        rst,                    // async reset
  input wire logic [5:0]  avs_address,            // byte address
  input wire logic        avs_read,               // read request
  input wire logic        avs_write,              // write request
  input wire logic [31:0] avs_writedata,          // write data
  input wire logic        avs_waitrequest,        // stall
  input wire logic [3:0]  chan_pin_in,            // channel pin levels
  input wire logic [3:0]  chan_pin_out,           // channel drive levels
  input wire logic [3:0]  chan_pin_oe,            // channel enables
  input wire logic        dual_wave,              // dual-pulse waveform
  input wire logic [3:0]  capture_in,             // capture inputs
  input wire logic        external_trigger_input, // trigger input
  input wire logic        shared_pin_in,          // shared pin level
  input wire logic        shared_pin_oe,          // shared pin enable
  input wire logic        hw_reset_req            // hardware reset request
);
  logic [3:0] dis_ff;
  logic [3:0] dir_ff;
  logic       dual_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // shadow of the config bits, updated at the edge the write is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dis_ff  <= RST_OUT_DISABLE;
      dir_ff  <= RST_PORT_DIR[3:0];
      dual_ff <= RST_TIMER_MODE[DUAL_SEL_BIT];
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == OFS_OUT_DISABLE) dis_ff <= avs_writedata[3:0];
      if (avs_address == OFS_PORT_DIR) dir_ff <= avs_writedata[3:0];
      if (avs_address == OFS_TIMER_MODE) dual_ff <= avs_writedata[DUAL_SEL_BIT];
    end
  end

  // ==========================================================================
  // assertions; pins follow the config seen one edge earlier
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("waitrequest not low for exactly one cycle");
  AST_RESET_IDLE: assert property ($fell(rst) |-> chan_pin_oe == 4'h0 && !shared_pin_oe)
    else $error("pin driven right after reset");
  AST_CAP_INPUT: assert property ((capture_in & chan_pin_oe) == 4'h0)
    else $error("capture on a driven pin");
  AST_CAP_LEVEL: assert property ((capture_in & ~$past(chan_pin_in)) == 4'h0)
    else $error("capture without pin high");
  AST_TRIG_LEVEL: assert property (external_trigger_input |-> $past(chan_pin_in[0]) && !chan_pin_oe[0])
    else $error("trigger not from input pin a");
  AST_HWRST_REQ: assert property (hw_reset_req |-> !$past(shared_pin_in) && !shared_pin_oe)
    else $error("reset request without low shared pin");
  AST_OE_CAUSE: assert property ((chan_pin_oe & $past(dis_ff & ~dir_ff)) == 4'h0)
    else $error("disabled input pin driven");
  AST_DUAL_B: assert property ($past(!dual_ff && !dis_ff[1]) |->
    chan_pin_oe[1] && chan_pin_out[1] == $past(dual_wave)) else $error("pin b not on dual waveform");

  COV_TRIG: cover property (external_trigger_input);
  COV_HWRST: cover property (hw_reset_req);
  COV_CAPTURE: cover property (capture_in != 4'h0);
endmodule

bind timer_pin_function_select timer_pin_props u_timer_pin_props (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .chan_pin_in(chan_pin_in),
  .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .dual_wave(dual_wave), .capture_in(capture_in),
  .external_trigger_input(external_trigger_input), .shared_pin_in(shared_pin_in),
  .shared_pin_oe(shared_pin_oe), .hw_reset_req(hw_reset_req));

// ### verif/timer_far_side.sv
// far-side model: timer waveforms and resolved external pin levels
`timescale 1ns/1ps
module timer_far_side (
  input  wire logic       clk,            // system clock
  input  wire logic       rst,            // async reset
  input  wire logic [3:0] chan_pin_out,   // block drive levels
  input  wire logic [3:0] chan_pin_oe,    // block enables
  input  wire logic       shared_pin_out, // shared drive level
  input  wire logic       shared_pin_oe,  // shared enable
  input  wire logic [3:0] ext_level,      // levels of outside sources
  input  wire logic       ext_reset_low,  // outside reset source pulls low
  output logic      [3:0] compare_wave,   // compare waveforms
  output logic      [3:0] pwm_wave,       // pwm waveforms
  output logic            dual_wave,      // dual-pulse waveform
  output logic      [3:0] chan_pin_in,    // resolved channel pins
  output logic            shared_pin_in   // resolved shared pin
);
  logic [7:0] cnt_ff;

  // ==========================================================================
  // waveforms are bits of a counter that steps every cycle so a stale selection shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  assign compare_wave = cnt_ff[3:0];
  assign pwm_wave     = cnt_ff[6:3];
  assign dual_wave    = cnt_ff[1];

  // ==========================================================================
  // each pin feeds only its own input, one source per input
  assign chan_pin_in   = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & ext_level);
  // shared pin has a pull-up
  assign shared_pin_in = ((shared_pin_oe && !shared_pin_out) || ext_reset_low) ? 1'b0 : 1'b1;
endmodule

// ### verif/test_timer_pin_function_select.sv
// self-checking bench for the timer pin-function selection block
`timescale 1ns/1ps
module test_timer_pin_function_select;
  import pin_select_pkg::*;
  typedef struct packed {
    logic [3:0]  dis;
    logic [7:0]  mode;
    logic [6:0]  io1;
    logic [6:0]  io2;
    logic [1:0]  edg;
    logic [11:0] fn;
  } row_t;
  localparam row_t ROWS [10] = '{
    '{4'hf, 8'h80, 7'h00, 7'h00, 2'h0, 12'h000}, '{4'h0, 8'h80, 7'h21, 7'h13, 2'h0, 12'h249},
    '{4'h0, 8'h8e, 7'h40, 7'h00, 2'h0, 12'h490}, '{4'hf, 8'h80, 7'h54, 7'h76, 2'h0, 12'h924},
    '{4'h0, 8'h00, 7'h00, 7'h00, 2'h1, 12'h018}, '{4'h1, 8'h00, 7'h00, 7'h00, 2'h1, 12'h01d},
    '{4'h1, 8'h00, 7'h00, 7'h00, 2'h2, 12'h01d}, '{4'h1, 8'h00, 7'h00, 7'h00, 2'h3, 12'h01d},
    '{4'h1, 8'h00, 7'h00, 7'h00, 2'h0, 12'h018}, '{4'h2, 8'h82, 7'h00, 7'h01, 2'h0, 12'h040}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  chan_pin_in, chan_pin_out, chan_pin_oe, compare_wave, pwm_wave, capture_in;
  logic        dual_wave, external_trigger_input, shared_pin_in, shared_pin_out, shared_pin_oe, hw_reset_req;
  logic [3:0]  ext_level = 4'h5;
  logic        ext_reset_low = 1'b0;
  int          err_count = 0;
  int          checks_done = 0;

  always #12.5 clk = ~clk;

  timer_pin_function_select u_timer_pin_function_select (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe(chan_pin_oe), .compare_wave(compare_wave), .pwm_wave(pwm_wave), .dual_wave(dual_wave),
    .capture_in(capture_in), .external_trigger_input(external_trigger_input), .shared_pin_in(shared_pin_in),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe), .hw_reset_req(hw_reset_req));
  timer_far_side u_timer_far_side (.clk(clk), .rst(rst), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
    .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe), .ext_level(ext_level),
    .ext_reset_low(ext_reset_low), .compare_wave(compare_wave), .pwm_wave(pwm_wave), .dual_wave(dual_wave),
    .chan_pin_in(chan_pin_in), .shared_pin_in(shared_pin_in));

  // ==========================================================================
  // verdict, compares and bus cycles
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t reg got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t pins got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      $display("BAD %0t bus timeout", $time);
      report_and_stop();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk_reg(q, exp);
  endtask
  // pins follow two edges after a write
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  // expected {trigger, capture, enable} for a function word
  function automatic logic [8:0] exp_pins(input logic [11:0] fn);
    logic [8:0] e;
    e = 9'h000;
    for (int i = 0; i < 4; i++) begin
      e[i]     = fn[3*i +: 3] inside {3'd1, 3'd2, 3'd3};
      e[4 + i] = (fn[3*i +: 3] == 3'd4) & ext_level[i];
    end
    e[8] = (fn[2:0] == 3'd5) & ext_level[0];
    return e;
  endfunction

  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    $display("BAD %0t run timeout", $time);
    report_and_stop();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFS_OUT_DISABLE, 32'hf);
    rdchk(OFS_TIMER_MODE, 32'h80);
    rdchk(OFS_PORT_DIR, 32'h0);
    rdchk(OFS_SHARED_MODE, 32'h11);
    rdchk(OFS_WRITE_PROT, 32'h0);
    rdchk(6'h3c, 32'h0);
    chk_pins({4'h0, shared_pin_oe, chan_pin_oe}, 9'h000);
    ext_reset_low <= 1'b1;
    settle();
    chk_pins({8'h00, hw_reset_req}, 9'h001);
    ext_reset_low <= 1'b0;
    settle();
    chk_pins({8'h00, hw_reset_req}, 9'h000);
    foreach (ROWS[i]) begin
      wr(OFS_OUT_DISABLE, {28'h0, ROWS[i].dis});
      wr(OFS_TIMER_MODE, {24'h0, ROWS[i].mode});
      wr(OFS_IO_FIRST, {25'h0, ROWS[i].io1});
      wr(OFS_IO_SECOND, {25'h0, ROWS[i].io2});
      wr(OFS_CTRL_SECOND, {30'h0, ROWS[i].edg});
      settle();
      chk_pins({external_trigger_input, capture_in, chan_pin_oe}, exp_pins(ROWS[i].fn));
      if (i == 1) chk_pins({5'h00, chan_pin_out}, {5'h00, compare_wave - 4'h1});
      rdchk(OFS_PIN_FUNCTION, {19'h0, 1'b1, ROWS[i].fn});
    end
    // ports once timer functions are off
    wr(OFS_OUT_DISABLE, 32'hf);
    wr(OFS_PORT_DATA, 32'h4);
    wr(OFS_PORT_DIR, 32'h5);
    settle();
    chk_pins({5'h00, chan_pin_oe}, 9'h005);
    chk_pins({5'h00, chan_pin_out & 4'h5}, 9'h004);
    // protected mode write first refused, then freeing the shared pin
    wr(OFS_SHARED_MODE, 32'h0);
    rdchk(OFS_SHARED_MODE, 32'h11);
    wr(OFS_WRITE_PROT, 32'h1);
    wr(OFS_SHARED_MODE, 32'h0);
    rdchk(OFS_SHARED_MODE, 32'h0);
    rdchk(OFS_PIN_FUNCTION, 32'h0);
    ext_reset_low <= 1'b1;
    settle();
    chk_pins({8'h00, hw_reset_req}, 9'h000);
    ext_reset_low <= 1'b0;
    wr(OFS_PORT_DATA, 32'h10);
    wr(OFS_PORT_DIR, 32'h10);
    settle();
    chk_pins({7'h00, shared_pin_oe, shared_pin_out}, 9'h003);
    report_and_stop();
  end
endmodule
